/* esi_pkg.sv */
// constants, field layouts and carrier types of the eight source interrupt unit
//
// Overview of operation
// - lines c and d mirror lines a and b: type, pending, enable, priority.
// - extra_irq_control_reg sits at address c0h and is bit addressable.
// - a bit set at bit address c2h sets line_c_enable_bit, bit 2.
// - line_d_priority_bit set puts line d at high level, else low.
// - line d requests service only while line_d_enable_bit is set.
// - line d is falling-edge triggered with type bit set, low-level when clear.
// - line_c_priority_bit set puts line c at high level, else low.
// - line c requests service only while line_c_enable_bit is set.
// - line c is falling-edge triggered with type bit set, low-level when clear.
// - line a vectors to 03h, rank 0, enable bit 0, type control bit 0.
// - line b vectors to 13h, rank 2, enable bit 2, type control bit 2.
// - line c vectors to 33h, rank 6, enable bit 2, type bit 0.
// - line d vectors to 3bh, rank 7, enable bit 6, type bit 4.
// - enabled level-mode line a or b wakes power-down; any enabled request ends idle.
package esi_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] TIMER_AND_EXT_IRQ_CONTROL_ADDR  = 8'h88;
   localparam logic [7:0] IE_ADDR    = 8'ha8;
   localparam logic [7:0] IP_ADDR    = 8'hb8;
   localparam logic [7:0] EXTRA_EXT_IRQ_CONTROL_ADDR = 8'hc0;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] TIMER_AND_EXT_IRQ_CONTROL_RST  = 8'h00;
   localparam logic [7:0] IE_RST    = 8'h00;
   localparam logic [7:0] IP_RST    = 8'h00;
   localparam logic [7:0] EXTRA_EXT_IRQ_CONTROL_RST = 8'h00;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int TC_TF1 = 7;
   localparam int TC_TF0 = 5;
   localparam int TC_TR0 = 4;
   localparam int TC_IE1 = 3;
   localparam int TC_IT1 = 2;
   localparam int TC_IE0 = 1;
   localparam int TC_IT0 = 0;
   localparam int IE_ALL = 7;
   localparam int XI_PX3 = 7;
   localparam int XI_EX3 = 6;
   localparam int XI_IE3 = 5;
   localparam int XI_IT3 = 4;
   localparam int XI_PX2 = 3;
   localparam int XI_EX2 = 2;
   localparam int XI_IE2 = 1;
   localparam int XI_IT2 = 0;

   // ----------------------------------------------------------------
   // sources by polling rank, and vector layout rank*8 + 3
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 8;
   localparam logic [2:0] SRC_LINE_A = 3'd0;
   localparam logic [2:0] SRC_TMR0   = 3'd1;
   localparam logic [2:0] SRC_LINE_B = 3'd2;
   localparam logic [2:0] SRC_TMR1   = 3'd3;
   localparam logic [2:0] SRC_SERIAL = 3'd4;
   localparam logic [2:0] SRC_TMR2   = 3'd5;
   localparam logic [2:0] SRC_LINE_C = 3'd6;
   localparam logic [2:0] SRC_LINE_D = 3'd7;
   localparam logic [2:0] VEC_LOW    = 3'b011;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       bit_wr;
      logic       bit_val;
      logic [7:0] addr;
      logic [7:0] wdata;
   } esi_sfr_req_t;

   typedef struct packed {
      logic       ack;
      logic       reti;
   } esi_core_ev_t;

endpackage

/* esi_pin_sync.sv */
// three stage pin synchroniser with agreement filter and falling edge pulse
`timescale 1ns/1ps
module esi_pin_sync #(
   parameter int N = 4
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [N-1:0] pin,
   output logic      [N-1:0] level,
   output logic      [N-1:0] fall
);
   logic [N-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, fall_reg;
   logic [N-1:0] lvl_next, fall_next;

   for (genvar i = 0; i < N; i++) begin : g_bit
      always_comb begin
         lvl_next[i]  = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
         fall_next[i] = lvl_reg[i] & ~lvl_next[i];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_reg   <= '1;
         s2_reg   <= '1;
         s3_reg   <= '1;
         lvl_reg  <= '1;
         fall_reg <= '0;
      end else begin
         s1_reg   <= pin;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         lvl_reg  <= lvl_next;
         fall_reg <= fall_next;
      end
   end

   assign level = lvl_reg;
   assign fall  = fall_reg;
endmodule

/* esi_first_set.sv */
// finds the lowest set index of a request vector
`timescale 1ns/1ps
module esi_first_set #(
   parameter int N = 8,
   parameter int W = 3
) (
   input  wire logic [N-1:0] req,
   output logic              valid,
   output logic      [W-1:0] idx
);
   always_comb begin
      valid = 1'b0;
      idx   = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            valid = 1'b1;
            idx   = W'(i);
         end
      end
   end
endmodule

/* esi_irq_unit.sv */
// two level, eight source interrupt unit with its four control registers
`timescale 1ns/1ps
module esi_irq_unit
   import esi_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire esi_pkg::esi_sfr_req_t sfr_req,
   output logic                [7:0] sfr_rdata,
   input  wire esi_pkg::esi_core_ev_t core_ev,
   output logic                      irq_req,
   output logic                [7:0] irq_vector,
   input  wire logic                 ext_request_line_a_n,
   input  wire logic                 ext_request_line_b_n,
   input  wire logic                 ext_request_line_c_n,
   input  wire logic                 ext_request_line_d_n,
   input  wire logic                 timer0_ovf,
   input  wire logic                 timer1_ovf,
   input  wire logic                 serial_req,
   input  wire logic                 timer2_req,
   output logic                [1:0] timer_run,
   output logic                      pd_wake,
   output logic                      idle_wake
);
   import esi_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers, lines a..d on bits 0..3
   // ----------------------------------------------------------------
   logic [3:0] lvl, fall;

   esi_pin_sync #(.N(4)) u_sync (
      .mclk  (mclk),
      .rst   (rst),
      .pin   ({ext_request_line_d_n, ext_request_line_c_n,
               ext_request_line_b_n, ext_request_line_a_n}),
      .level (lvl),
      .fall  (fall)
   );

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [7:0] timer_and_ext_irq_control_reg, timer_and_ext_irq_control_next;
   logic [7:0] ie_reg, ie_next;
   logic [7:0] ip_reg, ip_next;
   logic [7:0] extra_ext_irq_control_reg, extra_ext_irq_control_next;
   logic [7:0] rdata_reg, rdata_next;
   logic       req_reg, req_next;
   logic       hi_reg, hi_next;
   logic [2:0] idx_reg, idx_next;
   logic       hi_busy_reg, hi_busy_next;
   logic       lo_busy_reg, lo_busy_next;
   logic       pdw_reg, pdw_next;
   logic       idw_reg, idw_next;

   // byte write, or bit write addressed into the byte at off
   function automatic logic [7:0] sw_upd(input logic [7:0] cur, input logic [7:0] off,
                                         input esi_sfr_req_t q);
      logic [7:0] v;
      v = cur;
      if (q.wr && q.addr == off)
         v = q.wdata;
      if (q.bit_wr && {q.addr[7:3], 3'b000} == off)
         v[q.addr[2:0]] = q.bit_val;
      return v;
   endfunction

   // ----------------------------------------------------------------
   // source vector, enables and priorities by polling rank
   // ----------------------------------------------------------------
   logic [7:0] pend, en, prio, cand_hi, cand_lo;
   logic       hv, lv;
   logic [2:0] hidx, lidx;

   always_comb begin
      pend = {extra_ext_irq_control_reg[XI_IE3], extra_ext_irq_control_reg[XI_IE2], timer2_req, serial_req,
              timer_and_ext_irq_control_reg[TC_TF1], timer_and_ext_irq_control_reg[TC_IE1], timer_and_ext_irq_control_reg[TC_TF0], timer_and_ext_irq_control_reg[TC_IE0]};
      en   = {extra_ext_irq_control_reg[XI_EX3], extra_ext_irq_control_reg[XI_EX2], ie_reg[5:0]};
      prio = {extra_ext_irq_control_reg[XI_PX3], extra_ext_irq_control_reg[XI_PX2], ip_reg[5:0]};
      cand_hi = pend & en & prio & {8{ie_reg[IE_ALL]}};
      cand_lo = pend & en & ~prio & {8{ie_reg[IE_ALL]}};
   end

   esi_first_set #(.N(NUM_SRC), .W(3)) u_hi (
      .req   (cand_hi),
      .valid (hv),
      .idx   (hidx)
   );

   esi_first_set #(.N(NUM_SRC), .W(3)) u_lo (
      .req   (cand_lo),
      .valid (lv),
      .idx   (lidx)
   );

   // ----------------------------------------------------------------
   // register file next state
   // ----------------------------------------------------------------
   logic [3:0] ack_src;

   always_comb begin
      ack_src = '0;
      if (core_ev.ack && req_reg) begin
         case (idx_reg)
            SRC_LINE_A: ack_src[0] = 1'b1;
            SRC_LINE_B: ack_src[1] = 1'b1;
            SRC_LINE_C: ack_src[2] = 1'b1;
            SRC_LINE_D: ack_src[3] = 1'b1;
            default:    ack_src    = '0;
         endcase
      end
      ie_next = sw_upd(ie_reg, IE_ADDR, sfr_req);
      ip_next = sw_upd(ip_reg, IP_ADDR, sfr_req);

      timer_and_ext_irq_control_next = sw_upd(timer_and_ext_irq_control_reg, TIMER_AND_EXT_IRQ_CONTROL_ADDR, sfr_req);
      // timer flags: cleared on service, a new overflow wins
      if (core_ev.ack && req_reg && idx_reg == SRC_TMR0)
         timer_and_ext_irq_control_next[TC_TF0] = 1'b0;
      if (core_ev.ack && req_reg && idx_reg == SRC_TMR1)
         timer_and_ext_irq_control_next[TC_TF1] = 1'b0;
      if (timer0_ovf)
         timer_and_ext_irq_control_next[TC_TF0] = 1'b1;
      if (timer1_ovf)
         timer_and_ext_irq_control_next[TC_TF1] = 1'b1;
      // line a and b flags: edge latched, or following the level
      if (timer_and_ext_irq_control_reg[TC_IT0]) begin
         if (ack_src[0])
            timer_and_ext_irq_control_next[TC_IE0] = 1'b0;
         if (fall[0])
            timer_and_ext_irq_control_next[TC_IE0] = 1'b1;
      end else begin
         timer_and_ext_irq_control_next[TC_IE0] = ~lvl[0];
      end
      if (timer_and_ext_irq_control_reg[TC_IT1]) begin
         if (ack_src[1])
            timer_and_ext_irq_control_next[TC_IE1] = 1'b0;
         if (fall[1])
            timer_and_ext_irq_control_next[TC_IE1] = 1'b1;
      end else begin
         timer_and_ext_irq_control_next[TC_IE1] = ~lvl[1];
      end

      extra_ext_irq_control_next = sw_upd(extra_ext_irq_control_reg, EXTRA_EXT_IRQ_CONTROL_ADDR, sfr_req);
      // lines c and d mirror lines a and b
      if (extra_ext_irq_control_reg[XI_IT2]) begin
         if (ack_src[2])
            extra_ext_irq_control_next[XI_IE2] = 1'b0;
         if (fall[2])
            extra_ext_irq_control_next[XI_IE2] = 1'b1;
      end else begin
         extra_ext_irq_control_next[XI_IE2] = ~lvl[2];
      end
      if (extra_ext_irq_control_reg[XI_IT3]) begin
         if (ack_src[3])
            extra_ext_irq_control_next[XI_IE3] = 1'b0;
         if (fall[3])
            extra_ext_irq_control_next[XI_IE3] = 1'b1;
      end else begin
         extra_ext_irq_control_next[XI_IE3] = ~lvl[3];
      end

      rdata_next = rdata_reg;
      if (sfr_req.rd) begin
         case (sfr_req.addr)
            TIMER_AND_EXT_IRQ_CONTROL_ADDR:  rdata_next = timer_and_ext_irq_control_reg;
            IE_ADDR:    rdata_next = ie_reg;
            IP_ADDR:    rdata_next = ip_reg;
            EXTRA_EXT_IRQ_CONTROL_ADDR: rdata_next = extra_ext_irq_control_reg;
            default:    rdata_next = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // arbitration and in-service levels
   // ----------------------------------------------------------------
   always_comb begin
      req_next     = 1'b0;
      hi_next      = hi_reg;
      idx_next     = idx_reg;
      hi_busy_next = hi_busy_reg;
      lo_busy_next = lo_busy_reg;
      if (core_ev.reti) begin
         if (hi_busy_reg)
            hi_busy_next = 1'b0;
         else
            lo_busy_next = 1'b0;
      end
      if (core_ev.ack && req_reg) begin
         if (hi_reg)
            hi_busy_next = 1'b1;
         else
            lo_busy_next = 1'b1;
      end else if (hv && !hi_busy_reg) begin
         req_next = 1'b1;
         hi_next  = 1'b1;
         idx_next = hidx;
      end else if (lv && !hi_busy_reg && !lo_busy_reg) begin
         req_next = 1'b1;
         hi_next  = 1'b0;
         idx_next = lidx;
      end
      pdw_next = (ie_reg[0] && !timer_and_ext_irq_control_reg[TC_IT0] && !lvl[0]) ||
                 (ie_reg[2] && !timer_and_ext_irq_control_reg[TC_IT1] && !lvl[1]);
      idw_next = hv || lv;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         timer_and_ext_irq_control_reg    <= TIMER_AND_EXT_IRQ_CONTROL_RST;
         ie_reg      <= IE_RST;
         ip_reg      <= IP_RST;
         extra_ext_irq_control_reg   <= EXTRA_EXT_IRQ_CONTROL_RST;
         rdata_reg   <= 8'h00;
         req_reg     <= 1'b0;
         hi_reg      <= 1'b0;
         idx_reg     <= 3'h0;
         hi_busy_reg <= 1'b0;
         lo_busy_reg <= 1'b0;
         pdw_reg     <= 1'b0;
         idw_reg     <= 1'b0;
      end else begin
         timer_and_ext_irq_control_reg    <= timer_and_ext_irq_control_next;
         ie_reg      <= ie_next;
         ip_reg      <= ip_next;
         extra_ext_irq_control_reg   <= extra_ext_irq_control_next;
         rdata_reg   <= rdata_next;
         req_reg     <= req_next;
         hi_reg      <= hi_next;
         idx_reg     <= idx_next;
         hi_busy_reg <= hi_busy_next;
         lo_busy_reg <= lo_busy_next;
         pdw_reg     <= pdw_next;
         idw_reg     <= idw_next;
      end
   end

   assign sfr_rdata  = rdata_reg;
   assign irq_req    = req_reg;
   assign irq_vector = {2'b00, idx_reg, VEC_LOW};
   assign timer_run  = {timer_and_ext_irq_control_reg[6], timer_and_ext_irq_control_reg[TC_TR0]};
   assign pd_wake    = pdw_reg;
   assign idle_wake  = idw_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   line_d_gate_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req && idx_reg == SRC_LINE_D |-> $past(extra_ext_irq_control_reg[XI_EX3]))
      else $error("line d requested while disabled");

   line_c_gate_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req && idx_reg == SRC_LINE_C |-> $past(extra_ext_irq_control_reg[XI_EX2]))
      else $error("line c requested while disabled");

   line_d_level_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req && idx_reg == SRC_LINE_D && !$past(irq_req)
      |-> hi_reg == $past(extra_ext_irq_control_reg[XI_PX3]))
      else $error("line d served at wrong level");

   line_c_level_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req && idx_reg == SRC_LINE_C && !$past(irq_req)
      |-> hi_reg == $past(extra_ext_irq_control_reg[XI_PX2]))
      else $error("line c served at wrong level");

   d_edge_set_a: assert property (@(posedge mclk) disable iff (rst)
      extra_ext_irq_control_reg[XI_IT3] && fall[3] |=> extra_ext_irq_control_reg[XI_IE3])
      else $error("line d edge not latched");

   c_edge_set_a: assert property (@(posedge mclk) disable iff (rst)
      extra_ext_irq_control_reg[XI_IT2] && fall[2] |=> extra_ext_irq_control_reg[XI_IE2])
      else $error("line c edge not latched");

   d_service_clr_a: assert property (@(posedge mclk) disable iff (rst)
      core_ev.ack && irq_req && idx_reg == SRC_LINE_D && extra_ext_irq_control_reg[XI_IT3] && !fall[3]
      && !sfr_req.wr && !sfr_req.bit_wr |=> !extra_ext_irq_control_reg[XI_IE3])
      else $error("line d flag kept after service");

   c_level_follow_a: assert property (@(posedge mclk) disable iff (rst)
      !extra_ext_irq_control_reg[XI_IT2] |=> extra_ext_irq_control_reg[XI_IE2] == !$past(lvl[2]))
      else $error("line c level flag wrong");

   d_level_follow_a: assert property (@(posedge mclk) disable iff (rst)
      !extra_ext_irq_control_reg[XI_IT3] |=> extra_ext_irq_control_reg[XI_IE3] == !$past(lvl[3]))
      else $error("line d level flag wrong");

   vector_map_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req |-> irq_vector == {2'b00, idx_reg, 3'b011} && irq_vector[2:0] == 3'h3)
      else $error("vector not rank times eight plus three");

   hi_block_a: assert property (@(posedge mclk) disable iff (rst)
      $past(hi_busy_reg) && $past(hi_busy_next) |-> !irq_req)
      else $error("request raised during high handler");

   hi_first_a: assert property (@(posedge mclk) disable iff (rst)
      irq_req && !$past(irq_req) && $past(hv) |-> hi_reg && idx_reg == $past(hidx))
      else $error("low request beat a high one");

   bit_set_a: assert property (@(posedge mclk) disable iff (rst)
      sfr_req.bit_wr && sfr_req.addr == 8'hc2 && sfr_req.bit_val |=> extra_ext_irq_control_reg[XI_EX2])
      else $error("bit set at c2h missed enable");

   pd_wake_a: assert property (@(posedge mclk) disable iff (rst)
      ie_reg[0] && !timer_and_ext_irq_control_reg[TC_IT0] && !lvl[0] |=> pd_wake)
      else $error("power-down wake missing");
endmodule

/* esi_core_model.sv */
// processor core model: takes offered vectors and returns from handlers
`timescale 1ns/1ps
module esi_core_model
   import esi_pkg::*;
(
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 irq_req,
   input  wire logic           [7:0] irq_vector,
   input  wire logic                 ack_en,
   input  wire logic                 ret_go,
   output esi_pkg::esi_core_ev_t     core_ev,
   output logic                [7:0] got_vec,
   output int                        n_ack
);
   logic ack_reg;

   // ack is a one cycle pulse; the bench delays ack_en to act as a slow core
   assign core_ev = '{ack: ack_reg, reti: ret_go};

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
         got_vec <= 8'h00;
         n_ack   <= 0;
      end else begin
         ack_reg <= ack_en && irq_req && !ack_reg;
         if (ack_reg && irq_req) begin
            got_vec <= irq_vector;
            n_ack   <= n_ack + 1;
         end
      end
   end
endmodule

/* eight_source_interrupt_unit_test.sv */
// self-checking bench of the eight source interrupt unit
`timescale 1ns/1ps
module eight_source_interrupt_unit_test;
   import esi_pkg::*;
   logic         mclk = 1'b0;
   logic         rst  = 1'b1;
   esi_sfr_req_t req;
   esi_core_ev_t ev;
   logic [7:0]   rdata, vec, got;
   logic         irq, pa, pb, pc, pd, t0, t1, ser, t2, ack_en, ret_go, pdw, idw;
   logic [1:0]   trun;
   int           n_ack, n_fail, cmp_count, cyc;

   esi_irq_unit esi_irq_unit_i (
      .mclk(mclk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata), .core_ev(ev),
      .irq_req(irq), .irq_vector(vec), .ext_request_line_a_n(pa),
      .ext_request_line_b_n(pb), .ext_request_line_c_n(pc), .ext_request_line_d_n(pd),
      .timer0_ovf(t0), .timer1_ovf(t1), .serial_req(ser), .timer2_req(t2),
      .timer_run(trun), .pd_wake(pdw), .idle_wake(idw));

   esi_core_model esi_core_model_i (
      .mclk(mclk), .rst(rst), .irq_req(irq), .irq_vector(vec), .ack_en(ack_en),
      .ret_go(ret_go), .core_ev(ev), .got_vec(got), .n_ack(n_ack));

   always #2 mclk = ~mclk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic end_sim;
      if (n_fail == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         end_sim;
      end
   end

   task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic sfr(input logic r, w, b, v, input logic [7:0] a, d);
      @(posedge mclk) req <= '{rd: r, wr: w, bit_wr: b, bit_val: v, addr: a, wdata: d};
      @(posedge mclk) req <= '0;
   endtask

   task automatic wr8(input logic [7:0] a, d);
      sfr(1'b0, 1'b1, 1'b0, 1'b0, a, d);
   endtask

   task automatic bitw(input logic [7:0] a, input logic v);
      sfr(1'b0, 1'b0, 1'b1, v, a, 8'h00);
   endtask

   task automatic rdc(input logic [7:0] a, exp);
      sfr(1'b1, 1'b0, 1'b0, 1'b0, a, 8'h00);
      @(posedge mclk);
      #1 cmp(rdata, exp);
   endtask

   task automatic gap(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wait_req;
      for (int k = 0; k < 20 && irq !== 1'b1; k++) gap(1);
      cmp(8'(irq), 8'h01);
   endtask

   // lag idle cycles before the core agrees to take the vector
   task automatic take(input int lag, input logic [7:0] exp);
      int n0;
      n0 = n_ack;
      repeat (lag) @(posedge mclk);
      @(posedge mclk) ack_en <= 1'b1;
      for (int k = 0; k < 20 && n_ack == n0; k++) @(posedge mclk);
      ack_en <= 1'b0;
      #1 cmp(got, exp);
   endtask

   task automatic ret;
      @(posedge mclk) ret_go <= 1'b1;
      @(posedge mclk) ret_go <= 1'b0;
   endtask

   // raise or drop one source, indexed by polling rank
   task automatic set_src(input int i, input logic on);
      case (i)
         0: pa <= !on;
         1: t0 <= on;
         2: pb <= !on;
         3: t1 <= on;
         4: ser <= on;
         5: t2 <= on;
         6: pc <= !on;
         default: pd <= !on;
      endcase
      if ((i == 1 || i == 3) && on) begin
         @(posedge mclk);
         t0 <= 1'b0;
         t1 <= 1'b0;
      end
   endtask

   task automatic serve(input logic [7:0] exp);
      take(0, exp);
   endtask

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      req = '0;
      {pa, pb, pc, pd} = 4'hf;
      {t0, t1, ser, t2, ack_en, ret_go} = 6'h00;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rdc(TIMER_AND_EXT_IRQ_CONTROL_ADDR, TIMER_AND_EXT_IRQ_CONTROL_RST);
      rdc(IE_ADDR, IE_RST);
      rdc(IP_ADDR, IP_RST);
      rdc(EXTRA_EXT_IRQ_CONTROL_ADDR, EXTRA_EXT_IRQ_CONTROL_RST);
      rdc(8'hc1, 8'h00);
      wr8(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h44);
      rdc(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h44);
      bitw(8'hc2, 1'b0);
      rdc(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h40);
      bitw(8'hc2, 1'b1);
      rdc(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h44);
      wr8(TIMER_AND_EXT_IRQ_CONTROL_ADDR, 8'h50);
      gap(1);
      cmp(8'(trun), 8'h03);
      wr8(TIMER_AND_EXT_IRQ_CONTROL_ADDR, 8'h00);
      wr8(IE_ADDR, 8'hbf);
      // line c low level while disabled
      wr8(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h00);
      @(posedge mclk) pc <= 1'b0;
      gap(8);
      cmp(8'(irq), 8'h00);
      rdc(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h02);
      @(posedge mclk) pc <= 1'b1;
      // line d edge mode, enabled only after the edge
      wr8(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h10);
      @(posedge mclk) pd <= 1'b0;
      gap(8);
      cmp(8'(irq), 8'h00);
      rdc(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h30);
      bitw(8'hc6, 1'b1);
      wait_req;
      cmp(vec, 8'h3b);
      take(5, 8'h3b);
      rdc(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h50);
      ret;
      gap(8);
      cmp(8'(irq), 8'h00);
      @(posedge mclk) pd <= 1'b1;
      // let the filtered line d level rise before level mode follows it
      gap(6);
      // every source alone, external lines in level mode
      wr8(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h44);
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk) set_src(i, 1'b1);
         wait_req;
         cmp(vec, 8'(i * 8 + 3));
         if (i == 0) cmp(8'(pdw), 8'h01);
         cmp(8'(idw), 8'h01);
         serve(8'(i * 8 + 3));
         @(posedge mclk) set_src(i, 1'b0);
         gap(6);
         ret;
         gap(4);
         cmp(8'(irq), 8'h00);
      end
      // high line d beats rank 0, then preempts a low handler
      wr8(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'hc4);
      @(posedge mclk);
      set_src(0, 1'b1);
      set_src(7, 1'b1);
      wait_req;
      gap(4);
      cmp(vec, 8'h3b);
      serve(8'h3b);
      @(posedge mclk) set_src(7, 1'b0);
      gap(6);
      ret;
      wait_req;
      cmp(vec, 8'h03);
      serve(8'h03);
      @(posedge mclk) set_src(7, 1'b1);
      wait_req;
      cmp(vec, 8'h3b);
      serve(8'h3b);
      @(posedge mclk);
      set_src(0, 1'b0);
      set_src(7, 1'b0);
      gap(6);
      ret;
      ret;
      gap(4);
      cmp(8'(irq), 8'h00);
      // high line c beats rank 0
      wr8(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h0c);
      @(posedge mclk);
      set_src(0, 1'b1);
      set_src(6, 1'b1);
      wait_req;
      gap(4);
      cmp(vec, 8'h33);
      serve(8'h33);
      @(posedge mclk);
      set_src(0, 1'b0);
      set_src(6, 1'b0);
      gap(6);
      ret;
      // same level: lower rank wins
      wr8(EXTRA_EXT_IRQ_CONTROL_ADDR, 8'h00);
      @(posedge mclk);
      set_src(5, 1'b1);
      set_src(2, 1'b1);
      wait_req;
      // line b passes the pin filter after timer 2 is already offered
      gap(8);
      cmp(vec, 8'h13);
      serve(8'h13);
      @(posedge mclk);
      set_src(5, 1'b0);
      set_src(2, 1'b0);
      gap(6);
      ret;
      gap(4);
      end_sim;
   end
endmodule
